// file: rtl/ssw_defs.svh
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

// ****************************************
// timebase
// ****************************************
`define SSW_CLK_HZ          64'd20000000

// ****************************************
// documented times, in their own units
// ****************************************
`define SSW_RST_HOLD_MS     64'd140
`define SSW_WD_TIMEOUT_MS   64'd1600
`define SSW_MR_GLITCH_NS    64'd100
`define SSW_WD_DRV_HI_NUM   64'd1
`define SSW_WD_DRV_DEN      64'd8

// ****************************************
// derived cycle counts
// ****************************************
// least time: round up
`define SSW_RST_HOLD_CYC    ((`SSW_RST_HOLD_MS * `SSW_CLK_HZ + 64'd999) / 64'd1000)
// nominal period: round down
`define SSW_WD_TIMEOUT_CYC  ((`SSW_WD_TIMEOUT_MS * `SSW_CLK_HZ) / 64'd1000)
// glitch rejection: round down, never below one cycle
`define SSW_MR_FILT_RAW     ((`SSW_MR_GLITCH_NS * `SSW_CLK_HZ) / 64'd1000000000)
`define SSW_MR_FILT_CYC     ((`SSW_MR_FILT_RAW < 64'd1) ? 64'd1 : `SSW_MR_FILT_RAW)

// ****************************************
// reset values
// ****************************************
`define SSW_SYNC_RST        1'b0
`define SSW_MR_RST          1'b1

`endif

// file: rtl/ssw_pkg.sv
`default_nettype none

package ssw_pkg;

  // ****************************************
  // build-time options
  // ****************************************
  typedef enum {
    SSW_OUT_LOW_PP,
    SSW_OUT_LOW_OD,
    SSW_OUT_HIGH_PP
  } ssw_out_kind_t;

  typedef enum {
    SSW_SRC_ADJUST,
    SSW_SRC_SECOND
  } ssw_src_kind_t;

  // ****************************************
  // supply comparator flags (1 = below threshold)
  // ****************************************
  typedef struct packed {
    logic primary_below;
    logic adjustable_below;
    logic secondary_below;
  } ssw_mon_t;

  // ****************************************
  // reset sequencer
  // ****************************************
  typedef enum {
    SSW_ST_ASSERT,
    SSW_ST_HOLD,
    SSW_ST_RUN
  } ssw_state_t;

endpackage

`default_nettype wire

// file: rtl/ssw_top.sv

`include "ssw_defs.svh"

`default_nettype none

module ssw_top #(
  parameter ssw_pkg::ssw_out_kind_t OUT_KIND     = ssw_pkg::SSW_OUT_LOW_PP,
  parameter ssw_pkg::ssw_src_kind_t SRC_KIND     = ssw_pkg::SSW_SRC_ADJUST,
  parameter longint                 RST_HOLD_CYC = `SSW_RST_HOLD_CYC,
  parameter longint                 WD_CYC       = `SSW_WD_TIMEOUT_CYC,
  parameter int                     CW           = 26
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire ssw_pkg::ssw_mon_t mon_below,
  input  wire logic             manual_reset_n,
  input  wire logic             watchdog_kick_input_i,
  output logic                  watchdog_kick_input_o,
  output logic                  watchdog_kick_input_oe,
  output logic                  sup_reset_o,
  output logic                  sup_reset_oe,
  output logic                  sup_reset_active
);
  import ssw_pkg::*;

  // ****************************************
  // counts at counter width
  // ****************************************
  localparam logic [CW-1:0] HOLD_LAST = CW'(RST_HOLD_CYC - 64'd1);
  localparam logic [CW-1:0] WD_LAST   = CW'(WD_CYC - 64'd1);
  localparam logic [CW-1:0] DRV_RISE  =
    CW'((WD_CYC * (`SSW_WD_DRV_DEN - `SSW_WD_DRV_HI_NUM)) / `SSW_WD_DRV_DEN);
  localparam logic [CW-1:0] MR_LAST   = CW'(`SSW_MR_FILT_CYC - 64'd1);

  // one step of every up-counter, kept at counter width
  function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] cur);
    return cur + CW'(1);
  endfunction

  // ****************************************
  // local reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= `SSW_SYNC_RST;
      rst_sync_ff <= `SSW_SYNC_RST;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_n = rst_sync_ff;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // comparators are asynchronous to the timebase
  ssw_mon_t mon_meta_ff;
  ssw_mon_t mon_ff;
  logic     mr_meta_ff;
  logic     mr_ff;
  logic     kick_meta_ff;
  logic     kick_ff;
  logic     kick_prev_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_meta_ff  <= '1;
      mon_ff       <= '1;
      mr_meta_ff   <= `SSW_MR_RST;
      mr_ff        <= `SSW_MR_RST;
      kick_meta_ff <= `SSW_SYNC_RST;
      kick_ff      <= `SSW_SYNC_RST;
      kick_prev_ff <= `SSW_SYNC_RST;
    end else begin
      mon_meta_ff  <= mon_below;
      mon_ff       <= mon_meta_ff;
      mr_meta_ff   <= manual_reset_n;
      mr_ff        <= mr_meta_ff;
      kick_meta_ff <= watchdog_kick_input_i;
      kick_ff      <= kick_meta_ff;
      kick_prev_ff <= kick_ff;
    end
  end

  // every clock edge samples, so a 50 ns pulse spans at least one edge
  wire kick_edge = kick_ff ^ kick_prev_ff;

  // ****************************************
  // supply sources
  // ****************************************
  wire second_below = (SRC_KIND == SSW_SRC_ADJUST) ?
                      mon_ff.adjustable_below :
                      mon_ff.secondary_below;
  wire supply_below = mon_ff.primary_below | second_below;

  // ****************************************
  // manual input glitch filter
  // ****************************************
  // a low must stay for the filter time before it counts; bounce on
  // release just restarts the hold, giving one reset sequence
  logic [CW-1:0] mr_cnt_ff;
  logic          mr_low_ff;
  logic [CW-1:0] nxt_mr_cnt;
  logic          nxt_mr_low;

  wire mr_cnt_done = (mr_cnt_ff == MR_LAST);

  always_comb begin
    nxt_mr_cnt = '0;
    nxt_mr_low = 1'b0;
    if (!mr_ff) begin
      nxt_mr_cnt = mr_cnt_done ? mr_cnt_ff : cnt_step(mr_cnt_ff);
      nxt_mr_low = mr_low_ff | mr_cnt_done;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mr_cnt_ff <= '0;
      mr_low_ff <= 1'b0;
    end else begin
      mr_cnt_ff <= nxt_mr_cnt;
      mr_low_ff <= nxt_mr_low;
    end
  end

  // ****************************************
  // watchdog timer
  // ****************************************
  ssw_state_t    state_ff;
  logic [CW-1:0] wd_cnt_ff;
  logic [CW-1:0] nxt_wd_cnt;

  wire in_reset   = (state_ff != SSW_ST_RUN);
  wire wd_clear   = in_reset | mr_low_ff | kick_edge;
  wire wd_expire  = !wd_clear && (wd_cnt_ff == WD_LAST);

  assign nxt_wd_cnt = wd_clear ? '0 : cnt_step(wd_cnt_ff);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= '0;
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
    end
  end

  // ****************************************
  // internal kick driver
  // ****************************************
  // phase restarts with every reset so the rise at 7/8 always lands
  // before the timer runs out; an external driver overrides this level
  logic [CW-1:0] drv_cnt_ff;
  logic          drv_lvl_ff;
  logic [CW-1:0] nxt_drv_cnt;

  wire drv_wrap = (drv_cnt_ff == WD_LAST);

  assign nxt_drv_cnt = (in_reset || drv_wrap) ? '0 : cnt_step(drv_cnt_ff);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_cnt_ff <= '0;
      drv_lvl_ff <= 1'b0;
    end else begin
      drv_cnt_ff <= nxt_drv_cnt;
      drv_lvl_ff <= (nxt_drv_cnt >= DRV_RISE);
    end
  end

  // rise at 1.4 s seen as a kick edge clears the 1.6 s timer
  assign watchdog_kick_input_o  = drv_lvl_ff;
  assign watchdog_kick_input_oe = 1'b1;

  // ****************************************
  // reset sequencer
  // ****************************************
  logic [CW-1:0] hold_cnt_ff;
  ssw_state_t    nxt_state;
  logic [CW-1:0] nxt_hold_cnt;

  wire cause = supply_below | mr_low_ff | wd_expire;

  always_comb begin
    nxt_state    = state_ff;
    nxt_hold_cnt = '0;
    case (state_ff)
      SSW_ST_ASSERT: begin
        if (!cause) begin
          nxt_state = SSW_ST_HOLD;
        end
      end
      SSW_ST_HOLD: begin
        if (cause) begin
          nxt_state = SSW_ST_ASSERT;
        end else if (hold_cnt_ff == HOLD_LAST) begin
          nxt_state = SSW_ST_RUN;
        end else begin
          nxt_hold_cnt = cnt_step(hold_cnt_ff);
        end
      end
      SSW_ST_RUN: begin
        if (cause) begin
          nxt_state = SSW_ST_ASSERT;
        end
      end
      default: begin
        nxt_state = SSW_ST_ASSERT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= SSW_ST_ASSERT;
      hold_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  // held asserted from power-up, before the clock even runs
  logic rst_out_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_out_ff <= 1'b1;
    end else begin
      rst_out_ff <= (nxt_state != SSW_ST_RUN);
    end
  end

  // open drain only pulls low, the line floats while released
  assign sup_reset_active = rst_out_ff;
  assign sup_reset_o  = (OUT_KIND == SSW_OUT_HIGH_PP) ? rst_out_ff :
                        (OUT_KIND == SSW_OUT_LOW_OD)  ? 1'b0 :
                        !rst_out_ff;
  assign sup_reset_oe = (OUT_KIND == SSW_OUT_LOW_OD) ? rst_out_ff : 1'b1;

endmodule // ssw_top

`default_nettype wire

// file: sim/ssw_monitor.sv
`default_nettype none
module ssw_monitor #(
  parameter ssw_pkg::ssw_out_kind_t OUT_KIND     = ssw_pkg::SSW_OUT_LOW_PP,
  parameter ssw_pkg::ssw_src_kind_t SRC_KIND     = ssw_pkg::SSW_SRC_ADJUST,
  parameter longint                 RST_HOLD_CYC = 20,
  parameter longint                 WD_CYC       = 64
) (
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire ssw_pkg::ssw_mon_t mon_below,
  input wire logic              manual_reset_n,
  input wire logic              watchdog_kick_input_i,
  input wire logic              watchdog_kick_input_o,
  input wire logic              watchdog_kick_input_oe,
  input wire logic              sup_reset_o,
  input wire logic              sup_reset_oe,
  input wire logic              sup_reset_active
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssw_pkg::*;
  localparam int H = int'(RST_HOLD_CYC);
  localparam int W = int'(WD_CYC);
  logic q;
  logic k_ff;
  int   q_ff, a_ff, w_ff, h_ff;
  wire  act = sup_reset_active;
  // raw inputs, so sync delay is part of the margins
  assign q = !mon_below.primary_below && manual_reset_n &&
             !(SRC_KIND == SSW_SRC_ADJUST ? mon_below.adjustable_below : mon_below.secondary_below);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= 0;
      a_ff <= 0;
      w_ff <= 0;
      h_ff <= 0;
      k_ff <= 1'b0;
    end else begin
      q_ff <= q ? q_ff + 1 : 0;
      a_ff <= (act && q) ? a_ff + 1 : 0;
      w_ff <= (act || !manual_reset_n || watchdog_kick_input_i != k_ff) ? 0 : w_ff + 1;
      h_ff <= watchdog_kick_input_o ? h_ff + 1 : 0;
      k_ff <= watchdog_kick_input_i;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_mon_asserts: assert property (mon_below.primary_below [*5] |-> act)
    else $error("flag missed");
  a_mr_asserts: assert property (!manual_reset_n [*8] |-> act)
    else $error("manual low missed");
  a_out_level: assert property (sup_reset_oe |-> sup_reset_o == (OUT_KIND == SSW_OUT_HIGH_PP ? act : !act))
    else $error("pin level");
  a_out_enable: assert property (sup_reset_oe == (OUT_KIND != SSW_OUT_LOW_OD || act))
    else $error("pin enable");
  a_hold_min: assert property ($fell(act) |-> q_ff >= H)
    else $error("early release");
  a_hold_max: assert property (a_ff <= H + 12)
    else $error("late release");
  a_wd_expires: assert property (w_ff <= W + 8)
    else $error("no expiry");
  a_wd_not_early: assert property ($rose(act) |-> q_ff < 10 || w_ff >= W - 4)
    else $error("spurious reset");
  a_drv_high_len: assert property ($fell(watchdog_kick_input_o) && !act && !$past(act) |-> h_ff == W / 8)
    else $error("driver high");
  a_drv_enable: assert property (watchdog_kick_input_oe)
    else $error("driver enable");
  c_wd_fire: cover property ($rose(act) && w_ff >= W - 4);
  c_release: cover property ($fell(act));
  c_drv_fall: cover property ($fell(watchdog_kick_input_o));
endmodule // ssw_monitor
bind ssw_top ssw_monitor #(.OUT_KIND(OUT_KIND), .SRC_KIND(SRC_KIND), .RST_HOLD_CYC(RST_HOLD_CYC), .WD_CYC(WD_CYC))
  mon_u (.sys_clk(sys_clk), .arst_n(arst_n), .mon_below(mon_below), .manual_reset_n(manual_reset_n),
  .watchdog_kick_input_i(watchdog_kick_input_i), .watchdog_kick_input_o(watchdog_kick_input_o),
  .watchdog_kick_input_oe(watchdog_kick_input_oe), .sup_reset_o(sup_reset_o), .sup_reset_oe(sup_reset_oe),
  .sup_reset_active(sup_reset_active));
`default_nettype wire

// file: sim/ssw_cpu_model.sv
`default_nettype none
module ssw_cpu_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic kick_en,
  input wire logic [31:0] gap,
  output logic     kick_val,
  output logic     kick_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_ff;
  always_ff @(posedge clk) begin
    // a processor in reset floats its pins
    if (!reset_n || !kick_en) begin
      n_ff <= 0;
      kick_val <= 1'b0;
      kick_drv <= 1'b0;
    end else begin
      n_ff <= (n_ff + 1) % gap;
      kick_val <= n_ff == gap - 1;
      kick_drv <= 1'b1;
    end
  end
endmodule // ssw_cpu_model
`default_nettype wire

// file: sim/ssw_top_test.sv
`default_nettype none
module ssw_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ssw_pkg::*;
  localparam int H = 20;
  localparam int W = 64;
  logic       sys_clk, arst_n, mr_n, kick_en, kv, kd, act, ro, roe, ko, alt_act, alt_ko, prv;
  logic       alt_ro, od_ko, od_o, od_oe;
  ssw_mon_t   mon;
  int         gap, n, r, checked, bad_count;
  int         rises = 0;
  logic [31:0] seed;
  wire logic  kpin = kd ? kv : ko;
  wire logic  rpin_n = roe ? ro : 1'b1;
  // open-drain variant released: pull-up level
  wire logic  od_pin = od_oe ? od_o : 1'b1;
  ssw_top #(.RST_HOLD_CYC(H), .WD_CYC(W), .CW(8)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .mon_below(mon),
    .manual_reset_n(mr_n), .watchdog_kick_input_i(kpin), .watchdog_kick_input_o(ko), .watchdog_kick_input_oe(),
    .sup_reset_o(ro), .sup_reset_oe(roe), .sup_reset_active(act));
  ssw_top #(.OUT_KIND(SSW_OUT_HIGH_PP), .SRC_KIND(SSW_SRC_SECOND), .RST_HOLD_CYC(H), .WD_CYC(W), .CW(8)) alt_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .mon_below(mon), .manual_reset_n(mr_n), .watchdog_kick_input_i(alt_ko),
    .watchdog_kick_input_o(alt_ko), .watchdog_kick_input_oe(), .sup_reset_o(alt_ro), .sup_reset_oe(),
    .sup_reset_active(alt_act));
  ssw_top #(.OUT_KIND(SSW_OUT_LOW_OD), .RST_HOLD_CYC(H), .WD_CYC(W), .CW(8)) od_u (.sys_clk(sys_clk),
    .arst_n(arst_n), .mon_below(mon), .manual_reset_n(mr_n), .watchdog_kick_input_i(od_ko),
    .watchdog_kick_input_o(od_ko), .watchdog_kick_input_oe(), .sup_reset_o(od_o), .sup_reset_oe(od_oe),
    .sup_reset_active());
  ssw_cpu_model cpu_u (.clk(sys_clk), .reset_n(rpin_n), .kick_en(kick_en), .gap(gap), .kick_val(kv), .kick_drv(kd));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) prv <= act;
  always @(posedge sys_clk) if (act === 1'b1 && prv === 1'b0) rises++;
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tick(int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] lo, logic [31:0] hi, logic [31:0] g);
    logic ok;
    ok = g >= lo && g <= hi;
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %s expected %0d got %0d", nm, lo, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_act(logic v, logic alt);
    n = 0;
    while ((alt ? alt_act : act) !== v && n < 5000) begin
      tick(1);
      n++;
    end
    if (n >= 5000) begin
      bad_count++;
      results();
    end
  endtask
  initial begin
    {arst_n, mon, mr_n, kick_en, gap, checked, bad_count} = {1'b0, 3'h0, 1'b1, 1'b0, 32'h28, 64'h0};
    seed = 32'h4F72;
    tick(10);
    arst_n = 1'b1;
    wait_act(1'b0, 1'b0);
    chk("powerup", H, H + 12, n);
    for (int i = 0; i < 8; i++) begin
      mon = ssw_mon_t'(i[2:0]);
      tick(8);
      chk("dut_act", i[2] | i[1], i[2] | i[1], act);
      chk("alt_act", i[2] | i[0], i[2] | i[0], alt_act);
      chk("pin", !act, !act, ro);
      chk("alt_pin", alt_act, alt_act, alt_ro);
      chk("od_pin", !act, !act, od_pin);
      mon = '0;
      wait_act(1'b0, 1'b0);
      chk("hold", (i[2] | i[1]) ? H : 0, (i[2] | i[1]) ? H + 8 : 0, n);
      wait_act(1'b0, 1'b1);
    end
    r = rises;
    mr_n = 1'b0;
    tick(1);
    mr_n = 1'b1;
    tick(10);
    chk("mr_glitch", r, r, rises);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      mr_n = ~mr_n;
      tick(2 + int'(seed[1:0]));
    end
    mr_n = 1'b0;
    tick(20);
    chk("mr_low", 1, 1, act);
    mr_n = 1'b1;
    wait_act(1'b0, 1'b0);
    chk("mr_hold", H, H + 12, n);
    chk("mr_once", r + 1, r + 1, rises);
    kick_en = 1'b1;
    r = rises;
    tick(4 * W);
    chk("kicked", r, r, rises);
    gap = 100000;
    mr_n = 1'b0;
    tick(4);
    // manual reset must be seen before its release is awaited
    wait_act(1'b1, 1'b0);
    mr_n = 1'b1;
    wait_act(1'b0, 1'b0);
    wait_act(1'b1, 1'b0);
    chk("wd_expire", W - 2, W + 4, n);
    wait_act(1'b0, 1'b0);
    chk("wd_hold", H, H + 4, n);
    kick_en = 1'b0;
    r = rises;
    tick(4 * W);
    chk("undriven", r, r, rises);
    arst_n = 1'b0;
    tick(3);
    chk("arst_act", 1, 1, act);
    arst_n = 1'b1;
    wait_act(1'b0, 1'b0);
    chk("rearm", H, H + 12, n);
    results();
  end
endmodule // ssw_top_test
`default_nettype wire
